/* File: src/ioms_pkg.sv */
package ioms_pkg;
    // ********************************************************************
    // Sizes and timing
    // ********************************************************************
    localparam int IOMS_NCH = 8;
    localparam int IOMS_RTS_W = 15;
    localparam int IOMS_TIME_W = 64;
    localparam int IOMS_CLK_PERIOD_NS = 10;
    localparam int IOMS_MS_NS = 1_000_000;
    localparam int IOMS_MS_CYCLES = IOMS_MS_NS / IOMS_CLK_PERIOD_NS;
    localparam int IOMS_FIFO_DEPTH = 16;
    localparam logic [7:0] IOMS_FLT_BIAS = 8'h7F;

    // ********************************************************************
    // Reset values of the configuration
    // ********************************************************************
    localparam logic IOMS_RST_INT_FMT = 1'b0;
    localparam logic IOMS_RST_STAMP = 1'b0;
    localparam logic IOMS_RST_LATCH = 1'b0;
    localparam logic IOMS_RST_CLAMP = 1'b0;
    localparam logic [15:0] IOMS_RST_CLAMP_LO = 16'h8000;
    localparam logic [15:0] IOMS_RST_CLAMP_HI = 16'h7FFF;
    localparam logic [15:0] IOMS_RST_PROG_VALUE = 16'h0000;

    typedef struct packed {
        logic int_fmt;
        logic stamp_time;
        logic latch_en;
        logic clamp_en;
        logic [15:0] clamp_lo;
        logic [15:0] clamp_hi;
        logic [15:0] prog_value;
    } ioms_cfg_t;

    typedef struct packed {
        logic [2:0] chan;
        logic is_echo;
        logic [IOMS_RTS_W-1:0] rts;
        logic [IOMS_TIME_W-1:0] sys_time;
        logic [31:0] data;
    } ioms_rec_t;

    localparam int IOMS_REC_W = $bits(ioms_rec_t);

    // Signed 16-bit count to single precision; every such value is exact
    function automatic logic [31:0] ioms_to_float(input logic [15:0] v);
        logic [15:0] mag;
        logic [4:0] msb;
        logic [38:0] man;
        logic [31:0] r;
        mag = v[15] ? 16'(-v) : v;
        msb = 5'h00;
        r = 32'h0000_0000;
        for (int i = 0; i < 16; i++) begin
            if (mag[i]) begin
                msb = 5'(i);
            end
        end
        man = {mag, 23'h000000} >> msb;
        if (mag != 16'h0000) begin
            r = {v[15], 8'(IOMS_FLT_BIAS + {3'h0, msb}), man[22:0]};
        end
        return r;
    endfunction : ioms_to_float
endpackage : ioms_pkg

/* File: src/ioms_top.sv */
`timescale 1ns/10ps

// ************************************************************************
// Record FIFO between the service logic and the backplane consumer
// ************************************************************************
module ioms_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
            count <= (AW+1)'(count + push - pop);
        end
    end
endmodule : ioms_fifo

// Notes on behaviour
// - Free-running 15-bit counter advances once every millisecond, apart from chassis time.
// - Input variant captures the counter value at every channel scan.
// - Output variant updates reported counter only when the converter takes new values.
// - Records carry shared chassis time when the chosen format asks for it.
// - Records are produced unpolled into one stream any consumer may read.
// - With latching enabled, an alarm stays set after its condition disappears.
// - Integer format exchanges 16-bit signed two's complement channel values.
// - Floating format exchanges 32-bit IEEE single precision channel values.
// - Floating format is the default after configuration reset.
// - Output clamping is unavailable while integer format is selected.
// - Inhibited output variant enters program mode, outputs take program value.
// - Calibration indicator is lit while the module is in calibration mode.
// - Separate module status indicator shows the communication status.
// - Calibration runs on one selected channel or on all channels.
// - Configured sensor offset is added to each value during calculation.
module ioms_top
    import ioms_pkg::*;
#(
    parameter int MS_CYCLES = IOMS_MS_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic output_variant,
    input wire logic [IOMS_TIME_W-1:0] shared_chassis_time,
    input wire logic cfg_wr,
    input wire ioms_cfg_t cfg_data,
    output ioms_cfg_t cfg,
    input wire logic offset_wr,
    input wire logic [2:0] offset_chan,
    input wire logic [15:0] offset_value,
    input wire logic scan_valid,
    output logic scan_ready,
    input wire logic [2:0] scan_chan,
    input wire logic [15:0] scan_value,
    input wire logic cmd_wr,
    input wire logic [2:0] cmd_chan,
    input wire logic [15:0] cmd_value,
    input wire logic dac_apply,
    input wire logic [2:0] dac_chan,
    output logic dac_load,
    output logic [2:0] dac_load_chan,
    output logic [15:0] dac_code,
    output logic [IOMS_RTS_W-1:0] rolling_time,
    output logic [IOMS_RTS_W-1:0] reported_time,
    input wire logic inhibit,
    output logic program_mode,
    input wire logic connected,
    output logic module_status_led,
    input wire logic cal_start,
    input wire logic cal_all,
    input wire logic [2:0] cal_chan,
    input wire logic cal_done,
    output logic cal_led,
    output logic [IOMS_NCH-1:0] cal_chan_mask,
    input wire logic [IOMS_NCH-1:0] alarm_cond,
    input wire logic [IOMS_NCH-1:0] alarm_unlatch,
    output logic [IOMS_NCH-1:0] alarm,
    output logic rec_valid,
    input wire logic rec_ready,
    output ioms_rec_t rec_data
);
    typedef enum logic [0:0] {IOMS_CAL_IDLE, IOMS_CAL_RUN} ioms_cal_t;

    // ********************************************************************
    // Millisecond time base and rolling counter
    // ********************************************************************
    localparam int MS_W = $clog2(MS_CYCLES);
    localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);
    logic [MS_W-1:0] ms_div;
    wire ms_tick = ms_div == MS_LAST;

    always_ff @(posedge clk) begin
        if (reset) begin
            ms_div <= '0;
            rolling_time <= '0;
        end else begin
            ms_div <= ms_tick ? '0 : MS_W'(ms_div + 1'b1);
            // Plain width-limited increment wraps 7FFF to 0000
            if (ms_tick) begin
                rolling_time <= IOMS_RTS_W'(rolling_time + 1'b1);
            end
        end
    end

    // ********************************************************************
    // Configuration and per-channel tables
    // ********************************************************************
    logic [15:0] offset [IOMS_NCH];
    logic [15:0] cmd [IOMS_NCH];

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg.int_fmt <= IOMS_RST_INT_FMT;
            cfg.stamp_time <= IOMS_RST_STAMP;
            cfg.latch_en <= IOMS_RST_LATCH;
            cfg.clamp_en <= IOMS_RST_CLAMP;
            cfg.clamp_lo <= IOMS_RST_CLAMP_LO;
            cfg.clamp_hi <= IOMS_RST_CLAMP_HI;
            cfg.prog_value <= IOMS_RST_PROG_VALUE;
        end else if (cfg_wr) begin
            cfg <= cfg_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < IOMS_NCH; i++) begin
                offset[i] <= 16'h0000;
                cmd[i] <= 16'h0000;
            end
        end else begin
            if (offset_wr) begin
                offset[offset_chan] <= offset_value;
            end
            if (cmd_wr) begin
                cmd[cmd_chan] <= cmd_value;
            end
        end
    end

    // ********************************************************************
    // Value path: offset, clamp, program mode, format
    // ********************************************************************
    wire [2:0] sel_chan = output_variant ? dac_chan : scan_chan;
    wire [15:0] raw = output_variant ? cmd[dac_chan] : scan_value;
    wire [15:0] offs = offset[sel_chan];
    wire [16:0] sum = {raw[15], raw} + {offs[15], offs};
    wire sum_ovf = sum[16] != sum[15];
    wire [15:0] corrected = sum_ovf ? {sum[16], {15{~sum[16]}}} : sum[15:0];
    wire clamp_on = cfg.clamp_en && !cfg.int_fmt;
    wire below_lo = $signed(corrected) < $signed(cfg.clamp_lo);
    wire above_hi = $signed(corrected) > $signed(cfg.clamp_hi);
    wire [15:0] clamped = !clamp_on ? corrected :
                          below_lo ? cfg.clamp_lo :
                          above_hi ? cfg.clamp_hi : corrected;
    wire [15:0] applied = program_mode ? cfg.prog_value : clamped;
    wire [15:0] value = output_variant ? applied : corrected;
    wire [31:0] int_word = {{16{value[15]}}, value};
    wire [31:0] flt_word = ioms_to_float(value);
    wire [31:0] fmt_word = cfg.int_fmt ? int_word : flt_word;

    assign program_mode = output_variant && inhibit;

    // ********************************************************************
    // Record production
    // ********************************************************************
    logic fifo_ready;
    ioms_rec_t new_rec;
    wire event_req = output_variant ? dac_apply : scan_valid;
    wire push = event_req && fifo_ready;

    // Converter loads and scans stall while the stream is backed up
    assign scan_ready = fifo_ready && !output_variant;
    assign new_rec.chan = sel_chan;
    assign new_rec.is_echo = output_variant;
    assign new_rec.rts = rolling_time;
    assign new_rec.sys_time = cfg.stamp_time ? shared_chassis_time :
                              '0;
    assign new_rec.data = fmt_word;

    ioms_fifo #(
        .WIDTH(IOMS_REC_W),
        .DEPTH(IOMS_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(event_req),
        .in_ready(fifo_ready),
        .in_data(new_rec),
        .out_valid(rec_valid),
        .out_ready(rec_ready),
        .out_data(rec_data)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            reported_time <= '0;
            dac_load <= 1'b0;
            dac_load_chan <= 3'h0;
            dac_code <= IOMS_RST_PROG_VALUE;
        end else begin
            dac_load <= push && output_variant;
            if (push) begin
                reported_time <= rolling_time;
            end
            if (push && output_variant) begin
                dac_load_chan <= dac_chan;
                dac_code <= applied;
            end
        end
    end

    // ********************************************************************
    // Alarms
    // ********************************************************************
    wire [IOMS_NCH-1:0] keep = {IOMS_NCH{cfg.latch_en}} & alarm &
                               ~alarm_unlatch;
    wire [IOMS_NCH-1:0] next_alarm = alarm_cond | keep;

    always_ff @(posedge clk) begin
        if (reset) begin
            alarm <= '0;
        end else begin
            alarm <= next_alarm;
        end
    end

    // ********************************************************************
    // Calibration and indicators
    // ********************************************************************
    ioms_cal_t cal_state;
    ioms_cal_t next_cal_state;
    wire [IOMS_NCH-1:0] one_chan = IOMS_NCH'(1) << cal_chan;

    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            IOMS_CAL_IDLE: begin
                if (cal_start) begin
                    next_cal_state = IOMS_CAL_RUN;
                end
            end
            IOMS_CAL_RUN: begin
                if (cal_done) begin
                    next_cal_state = IOMS_CAL_IDLE;
                end
            end
            default: next_cal_state = IOMS_CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cal_state <= IOMS_CAL_IDLE;
            cal_chan_mask <= '0;
        end else begin
            cal_state <= next_cal_state;
            if (cal_state == IOMS_CAL_IDLE && cal_start) begin
                cal_chan_mask <= cal_all ? '1 : one_chan;
            end else if (cal_state == IOMS_CAL_RUN && cal_done) begin
                cal_chan_mask <= '0;
            end
        end
    end

    assign cal_led = cal_state == IOMS_CAL_RUN;
    assign module_status_led = connected && !inhibit;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_rts_tick: assert property (
        ms_tick |=> rolling_time == IOMS_RTS_W'($past(rolling_time) + 1'b1))
        else $error("rolling counter did not advance on tick");
    chk_rts_hold: assert property (
        !ms_tick |=> $stable(rolling_time))
        else $error("rolling counter moved between ticks");
    chk_rts_wrap: assert property (
        ms_tick && rolling_time == '1 |=> rolling_time == '0)
        else $error("rolling counter did not wrap to zero");
    chk_rep_only_event: assert property (
        !push |=> $stable(reported_time))
        else $error("reported time changed without an event");
    chk_rep_capture: assert property (
        push |=> reported_time == $past(rolling_time))
        else $error("reported time not captured at event");
    chk_alarm_latch: assert property (
        cfg.latch_en |=>
        ($past(alarm) & ~$past(alarm_unlatch) & ~alarm) == '0)
        else $error("latched alarm dropped");
    chk_alarm_clear: assert property (
        cfg.latch_en && alarm_unlatch[3] && !alarm_cond[3] |=> !alarm[3])
        else $error("unlatched alarm stayed set");
    chk_alarm_cond: assert property (
        alarm_cond != '0 |=>
        (alarm & $past(alarm_cond)) == $past(alarm_cond))
        else $error("present alarm condition not shown");
    chk_prog_mode: assert property (
        output_variant && inhibit && push |=>
        dac_code == $past(cfg.prog_value))
        else $error("inhibited output did not take program value");
    chk_int_word: assert property (
        cfg.int_fmt && push |->
        new_rec.data[31:16] == {16{new_rec.data[15]}})
        else $error("integer word not sign extended");
    chk_cal_led: assert property (
        cal_state == IOMS_CAL_IDLE && cal_start |=> cal_led [*1] ##0
        cal_chan_mask != '0)
        else $error("calibration indicator not lit");
    chk_status_led: assert property (
        inhibit |-> !module_status_led)
        else $error("status indicator lit while inhibited");

    cov_scan_rec: cover property (
        !output_variant && push ##[1:4] rec_valid && rec_ready);
    cov_dac_inhibit: cover property (output_variant && inhibit && push);
    cov_fifo_full: cover property (event_req && !fifo_ready);
    cov_cal_all: cover property (cal_start && cal_all ##[1:20] cal_done);
endmodule : ioms_top

/* File: verif/ioms_consumer.sv */
`timescale 1ns/10ps

// ************************************************************************
// Backplane consumer: takes produced records unless inhibited, can stall or go slow
// ************************************************************************
module ioms_consumer
    import ioms_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic stall,
    input wire logic slow,
    input wire logic inhibit,
    input wire logic rec_valid,
    output logic rec_ready,
    input wire ioms_rec_t rec_data
);
    ioms_rec_t recs[$];
    logic phase;

    always @(posedge clk) begin
        if (reset) begin
            phase <= 1'b0;
            rec_ready <= 1'b0;
        end else begin
            phase <= !phase;
            // An inhibited link is treated as absent, so nothing is taken
            rec_ready <= !stall && !inhibit && (!slow || phase);
            if (rec_valid && rec_ready) begin
                recs.push_back(rec_data);
            end
        end
    end
endmodule : ioms_consumer

/* File: verif/testbench.sv */
`timescale 1ns/10ps

module testbench
    import ioms_pkg::*;
;
    localparam int MS = 2;
    localparam logic [63:0] TIME = 64'h0123_4567_89AB_CDEF;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic output_variant = 1'b0;
    logic [IOMS_TIME_W-1:0] shared_chassis_time = TIME;
    logic cfg_wr = 1'b0, offset_wr = 1'b0, scan_valid = 1'b0, cmd_wr = 1'b0;
    logic dac_apply = 1'b0, inhibit = 1'b0, connected = 1'b0;
    logic cal_start = 1'b0, cal_all = 1'b0, cal_done = 1'b0;
    logic stall = 1'b0, slow = 1'b0;
    logic [2:0] offset_chan = 3'h0, scan_chan = 3'h0, cmd_chan = 3'h0;
    logic [2:0] dac_chan = 3'h0, cal_chan = 3'h0;
    logic [15:0] offset_value = 16'h0000, scan_value = 16'h0000;
    logic [15:0] cmd_value = 16'h0000;
    logic [7:0] alarm_cond = 8'h00, alarm_unlatch = 8'h00;
    ioms_cfg_t cfg_data = '0;
    ioms_cfg_t cfg, c;
    logic scan_ready, dac_load, program_mode, module_status_led, cal_led;
    logic rec_valid, rec_ready;
    logic [2:0] dac_load_chan;
    logic [15:0] dac_code;
    logic [14:0] rolling_time, reported_time, t;
    logic [7:0] cal_chan_mask, alarm;
    ioms_rec_t rec_data, r;
    int n_errors = 0, num_checks = 0, cycles = 0;

    ioms_top #(.MS_CYCLES(MS)) i_ioms_top(.clk, .reset, .output_variant,
        .shared_chassis_time, .cfg_wr, .cfg_data, .cfg, .offset_wr,
        .offset_chan, .offset_value, .scan_valid, .scan_ready, .scan_chan,
        .scan_value, .cmd_wr, .cmd_chan, .cmd_value, .dac_apply, .dac_chan,
        .dac_load, .dac_load_chan, .dac_code, .rolling_time, .reported_time,
        .inhibit, .program_mode, .connected, .module_status_led, .cal_start,
        .cal_all, .cal_chan, .cal_done, .cal_led, .cal_chan_mask, .alarm_cond,
        .alarm_unlatch, .alarm, .rec_valid, .rec_ready, .rec_data);
    ioms_consumer i_ioms_consumer(.clk, .reset, .stall, .slow, .inhibit,
        .rec_valid, .rec_ready, .rec_data);

    always #5 clk = ~clk;

    // ********************************************************************
    // Shared tasks
    // ********************************************************************
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // Wrap test needs about 66k cycles at two clocks per ms; a hang ends here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 70000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic do_reset(input logic ov);
        @(posedge clk);
        reset <= 1'b1;
        output_variant <= ov;
        tick(3);
        reset <= 1'b0;
    endtask : do_reset

    task automatic set_cfg(input ioms_cfg_t v);
        while (inhibit) @(posedge clk);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_data <= v;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask : set_cfg

    task automatic pop;
        int k = 0;
        while (i_ioms_consumer.recs.size() == 0 && k < 200) begin
            @(posedge clk);
            k++;
        end
        check(64'(k < 200), 64'h1);
        if (k < 200) r = i_ioms_consumer.recs.pop_front();
        else r = '0;
    endtask : pop

    task automatic scan(input logic [2:0] ch, input logic [15:0] v);
        int k = 0;
        @(posedge clk);
        scan_valid <= 1'b1;
        scan_chan <= ch;
        scan_value <= v;
        do begin
            @(posedge clk);
            k++;
        end while (!scan_ready && k < 50);
        t = rolling_time;
        scan_valid <= 1'b0;
    endtask : scan

    task automatic scan_chk(input logic [2:0] ch, input logic [15:0] v,
                            input logic [31:0] e, input logic [63:0] s);
        scan(ch, v);
        pop();
        check(r.data, e);
        check(r.sys_time, s);
        check(r.rts, t);
        check({r.chan, r.is_echo}, {ch, 1'b0});
        check(reported_time, t);
    endtask : scan_chk

    task automatic apply(input logic [2:0] ch, input logic [15:0] e,
                         input logic echo);
        @(posedge clk);
        dac_apply <= 1'b1;
        dac_chan <= ch;
        @(posedge clk);
        t = rolling_time;
        dac_apply <= 1'b0;
        @(posedge clk);
        check({dac_load, dac_load_chan}, {1'b1, ch});
        check(dac_code, e);
        check(reported_time, t);
        @(posedge clk);
        check(dac_load, 1'b0);
        if (echo) begin
            pop();
            check({r.is_echo, r.rts}, {1'b1, t});
        end
    endtask : apply

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic t_defaults;
        @(posedge clk);
        check(cfg.int_fmt, 1'b0);
        check({rec_valid, alarm, scan_ready}, 10'h001);
        c = '0;
        c.stamp_time = 1'b1;
    endtask : t_defaults

    task automatic t_rolling;
        logic [14:0] a;
        @(posedge clk);
        a = rolling_time;
        tick(MS);
        check(rolling_time, a + 15'h1);
    endtask : t_rolling

    task automatic t_format;
        @(posedge clk);
        offset_wr <= 1'b1;
        offset_chan <= 3'h2;
        offset_value <= 16'h0001;
        @(posedge clk);
        offset_wr <= 1'b0;
        set_cfg(c);
        scan_chk(3'h2, 16'h0002, 32'h4040_0000, TIME);
        scan_chk(3'h0, 16'hFFFE, 32'hC000_0000, TIME);
        c.int_fmt = 1'b1;
        c.stamp_time = 1'b0;
        set_cfg(c);
        scan_chk(3'h2, 16'hFFFD, 32'hFFFF_FFFE, 64'h0);
    endtask : t_format

    task automatic t_fifo;
        @(posedge clk);
        stall <= 1'b1;
        tick(2);
        for (int i = 0; i < IOMS_FIFO_DEPTH; i++) scan(3'h3, 16'(i));
        @(posedge clk);
        check(scan_ready, 1'b0);
        slow <= 1'b1;
        stall <= 1'b0;
        for (int i = 0; i < IOMS_FIFO_DEPTH; i++) begin
            pop();
            check(r.data, 64'(i));
        end
    endtask : t_fifo

    task automatic t_alarm;
        c.latch_en = 1'b1;
        set_cfg(c);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            alarm_cond <= 8'h08;
            alarm_unlatch <= {4'h0, i[0], 3'h0};
            @(posedge clk);
            alarm_cond <= 8'h00;
            alarm_unlatch <= 8'h00;
            tick(3);
            check(alarm, 8'h08);
        end
        alarm_unlatch <= 8'h08;
        @(posedge clk);
        alarm_unlatch <= 8'h00;
        tick(2);
        check(alarm, 8'h00);
    endtask : t_alarm

    task automatic t_cal;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            cal_start <= 1'b1;
            cal_all <= i[0];
            cal_chan <= 3'h4;
            @(posedge clk);
            cal_start <= 1'b0;
            @(posedge clk);
            check(cal_led, 1'b1);
            cal_start <= 1'b1;
            cal_all <= !i[0];
            @(posedge clk);
            cal_start <= 1'b0;
            tick(2);
            check(cal_chan_mask, i[0] ? 8'hFF : 8'h10);
            cal_done <= 1'b1;
            @(posedge clk);
            cal_done <= 1'b0;
            tick(2);
            check(cal_led, 1'b0);
        end
    endtask : t_cal

    task automatic t_wrap;
        while (rolling_time != 15'h7FFF) @(posedge clk);
        @(posedge clk);
        while (rolling_time == 15'h7FFF) @(posedge clk);
        check(rolling_time, 15'h0000);
    endtask : t_wrap

    task automatic t_output;
        c = '0;
        c.clamp_en = 1'b1;
        c.clamp_lo = 16'h8000;
        c.clamp_hi = 16'h0010;
        c.prog_value = 16'h1234;
        set_cfg(c);
        @(posedge clk);
        cmd_wr <= 1'b1;
        cmd_chan <= 3'h1;
        cmd_value <= 16'h0100;
        @(posedge clk);
        cmd_wr <= 1'b0;
        apply(3'h1, 16'h0010, 1'b1);
        tick(3 * MS);
        check(reported_time, t);
        c.int_fmt = 1'b1;
        set_cfg(c);
        apply(3'h1, 16'h0100, 1'b1);
        check(r.data, 32'h0000_0100);
    endtask : t_output

    task automatic t_inhibit;
        @(posedge clk);
        connected <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        check({module_status_led, program_mode}, 2'b10);
        inhibit <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        check({module_status_led, program_mode}, 2'b01);
        apply(3'h1, 16'h1234, 1'b0);
    endtask : t_inhibit

    initial begin
        do_reset(1'b0);
        t_defaults();
        t_rolling();
        t_format();
        t_fifo();
        t_alarm();
        t_cal();
        t_wrap();
        do_reset(1'b1);
        t_output();
        t_inhibit();
        end_sim();
    end
endmodule : testbench
